// file: rtl/afe_clock_control_error_status_regs.sv
// Purpose: Clock control, front-end control and error status register bank
// Assumes: Detector inputs are asynchronous analog comparator levels
// Notes:   Status capture is frozen while the digital clock gate is off
`timescale 1ns/1ns

// Summary of operation
// - Clock-control bit 2 gates the digital core clock; resets off.
// - Clock-control bit 1 picks crystal oscillator or external clock pin.
// - Clock-control bit 0 enables the clock pin output driver.
// - Rate register bits 5..3 pick fast modulator clock per channel.
// - Rate register bits 2..0 enable amplifier high resolution per channel.
// - Shutdown register powers down modulators (5..3) and amplifiers (2..0).
// - Fault register bits 2..0 disable amplifier fault detection.
// - Pace bit 2 routes pace to drive input, drive amp to reference.
// - Pace bit 1 routes pace to Wilson pin, detaching Wilson output.
// - Pace bit 0 powers down pace channel and resets to one.
// - Lead-off status holds one bit per input, input 6 as MSB.
// - Error status registers only update while the digital gate is on.
// - Summary register reports sync, channel, lead-off, battery, rail, range.
// - Low-battery bit is set when the monitor reports below 2.7 V.
// - Channel range registers report over range, sign and rail flags.
// - Sign bit is zero when positive output exceeds negative output.
// - Channel 3 range register shares the layout, bit 7 reserved.
module afe_clock_control_error_status_regs
    import afe_regs_pkg::*;
#(
    parameter int NUM_CHANNELS = 3,
    parameter int NUM_INPUTS   = 6
)(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [5:0] per_input_lead_off,
    input  wire logic       sync_error_flag,
    input  wire logic       low_battery_flag,
    input  wire logic       drive_near_rail_flag,
    input  wire logic       common_mode_range_flag,
    input  wire logic [2:0] modulator_over_range,
    input  wire logic [2:0] amp_output_sign,
    input  wire logic [2:0] neg_out_low_rail,
    input  wire logic [2:0] neg_out_high_rail,
    input  wire logic [2:0] pos_out_low_rail,
    input  wire logic [2:0] pos_out_high_rail,
    input  wire logic [2:0] diff_out_of_range,
    output logic            digital_clock_gate,
    output logic            clock_source_select,
    output logic            oscillator_power_down,
    output logic            clock_pin_drive_enable,
    output logic      [2:0] fast_mod_clock_sel,
    output logic      [2:0] high_resolution_enable,
    output logic      [2:0] modulator_power_down,
    output logic      [2:0] amplifier_power_down,
    output logic      [2:0] fault_detect_disable,
    output logic            pace_to_drive_input,
    output logic            drive_amp_to_reference_pin,
    output logic            pace_to_wilson_pin,
    output logic            wilson_output_detach,
    output logic            pace_channel_power_down
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The map holds exactly three channels and six inputs
    if (NUM_CHANNELS != 3 || NUM_INPUTS != 6)
    begin : g_bad_params
        $error("bank supports only three channels and six inputs");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Bit offsets of each detector field inside the synchroniser bundle;
    // they follow the concatenation order of det_raw, last field first
    localparam int OFS_DIFF     = 0;
    localparam int OFS_POS_HIGH = OFS_DIFF + NUM_CHANNELS;
    localparam int OFS_POS_LOW  = OFS_POS_HIGH + NUM_CHANNELS;
    localparam int OFS_NEG_HIGH = OFS_POS_LOW + NUM_CHANNELS;
    localparam int OFS_NEG_LOW  = OFS_NEG_HIGH + NUM_CHANNELS;
    localparam int OFS_SIGN     = OFS_NEG_LOW + NUM_CHANNELS;
    localparam int OFS_OVER     = OFS_SIGN + NUM_CHANNELS;
    localparam int OFS_CM       = OFS_OVER + NUM_CHANNELS;
    localparam int OFS_RAIL     = OFS_CM + 1;
    localparam int OFS_BATTERY  = OFS_RAIL + 1;
    localparam int OFS_SYNC     = OFS_BATTERY + 1;
    localparam int OFS_LEAD_OFF = OFS_SYNC + 1;
    localparam int DET_W        = OFS_LEAD_OFF + NUM_INPUTS;

    logic [7:0]       clk_ctl_r;
    logic [7:0]       rate_res_r;
    logic [7:0]       shutdown_r;
    logic [7:0]       fault_r;
    logic [7:0]       pace_r;
    logic [7:0]       lead_off_r;
    logic [7:0]       summary_r;
    logic [7:0]       range_r [NUM_CHANNELS];
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;
    logic [DET_W-1:0] det_raw;
    logic [DET_W-1:0] det_meta_r;
    logic [DET_W-1:0] det_sync_r;
    logic [7:0]       range_nxt [NUM_CHANNELS];
    logic [7:0]       summary_nxt;
    logic [7:0]       lead_off_nxt;
    logic             any_lead_off_flag;
    logic [2:0]       channel_range_error;
    logic             status_update;

    // ------------------------------------------------------------------
    // Detector synchroniser
    // ------------------------------------------------------------------
    // All detector levels are bundled so one two-stage chain serves them
    assign det_raw = {per_input_lead_off, sync_error_flag, low_battery_flag,
                      drive_near_rail_flag, common_mode_range_flag,
                      modulator_over_range, amp_output_sign,
                      neg_out_low_rail, neg_out_high_rail,
                      pos_out_low_rail, pos_out_high_rail,
                      diff_out_of_range};

    // Second stage is the only reader of the first
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            det_meta_r <= '0;
            det_sync_r <= '0;
        end
        else if (clk_en)
        begin
            det_meta_r <= det_raw;
            det_sync_r <= det_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Status assembly
    // ------------------------------------------------------------------
    // Per-channel range words, bit 7 reserved
    generate
        for (genvar ch = 0; ch < NUM_CHANNELS; ch++)
        begin : g_range
            assign range_nxt[ch] = {1'b0,
                                    det_sync_r[OFS_OVER + ch],
                                    det_sync_r[OFS_SIGN + ch],
                                    det_sync_r[OFS_NEG_LOW + ch],
                                    det_sync_r[OFS_NEG_HIGH + ch],
                                    det_sync_r[OFS_POS_LOW + ch],
                                    det_sync_r[OFS_POS_HIGH + ch],
                                    det_sync_r[OFS_DIFF + ch]};
            assign channel_range_error[ch] = |{range_nxt[ch][6],
                                               range_nxt[ch][4:0]};
        end
    endgenerate

    // Sign is a polarity report, not a fault, so it stays out of the OR
    assign lead_off_nxt      = {2'b00,
                                det_sync_r[OFS_LEAD_OFF +: 6]};
    assign any_lead_off_flag = |det_sync_r[OFS_LEAD_OFF +: 6];
    assign summary_nxt       = {det_sync_r[OFS_SYNC],
                                channel_range_error,
                                any_lead_off_flag,
                                det_sync_r[OFS_BATTERY],
                                det_sync_r[OFS_RAIL],
                                det_sync_r[OFS_CM]};

    // Gate off freezes the error view; captures resume on re-enable
    assign status_update = clk_en &
                           clk_ctl_r[BIT_DIGITAL_CLOCK_GATE];

    // Status registers take only detector values; bus writes never land
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            lead_off_r <= RST_STATUS;
            summary_r  <= RST_STATUS;
            for (int i = 0; i < NUM_CHANNELS; i++)
            begin
                range_r[i] <= RST_STATUS;
            end
        end
        else if (status_update)
        begin
            lead_off_r <= lead_off_nxt;
            summary_r  <= summary_nxt;
            for (int i = 0; i < NUM_CHANNELS; i++)
            begin
                range_r[i] <= range_nxt[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Write decodes; masks drop reserved bits before storage
    logic wr_clk_ctl;
    logic wr_rate;
    logic wr_shdn;
    logic wr_fault;
    logic wr_pace;
    assign wr_clk_ctl = reg_wr && (reg_addr == ADDR_CLOCK_SOURCE_CONTROL);
    assign wr_rate    = reg_wr && (reg_addr == ADDR_FRONTEND_RATE_RES);
    assign wr_shdn    = reg_wr && (reg_addr == ADDR_FRONTEND_SHUTDOWN);
    assign wr_fault   = reg_wr && (reg_addr == ADDR_FAULT_DETECT_CONTROL);
    assign wr_pace    = reg_wr && (reg_addr == ADDR_PACE_OUTPUT_ROUTING);

    // The gate is not interlocked with the source select; software
    // must sequence them, which keeps the bank a plain store
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_ctl_r  <= RST_CLOCK_SOURCE_CONTROL;
            rate_res_r <= RST_FRONTEND_RATE_RES;
            shutdown_r <= RST_FRONTEND_SHUTDOWN;
            fault_r    <= RST_FAULT_DETECT_CONTROL;
            pace_r     <= RST_PACE_OUTPUT_ROUTING;
        end
        else if (clk_en)
        begin
            if (wr_clk_ctl)
                clk_ctl_r  <= reg_wdata & MASK_CLOCK_SOURCE_CONTROL;
            if (wr_rate)
                rate_res_r <= reg_wdata & MASK_FRONTEND_RATE_RES;
            if (wr_shdn)
                shutdown_r <= reg_wdata & MASK_FRONTEND_SHUTDOWN;
            if (wr_fault)
                fault_r    <= reg_wdata & MASK_FAULT_DETECT_CONTROL;
            if (wr_pace)
                pace_r     <= reg_wdata & MASK_PACE_OUTPUT_ROUTING;
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    assign digital_clock_gate     = clk_ctl_r[BIT_DIGITAL_CLOCK_GATE];
    assign clock_source_select    = clk_ctl_r[BIT_CLOCK_SOURCE_SELECT];
    assign oscillator_power_down  = clk_ctl_r[BIT_CLOCK_SOURCE_SELECT];
    assign clock_pin_drive_enable = clk_ctl_r[BIT_CLOCK_PIN_DRIVE_ENABLE];
    assign fast_mod_clock_sel     =
        rate_res_r[LSB_FAST_MOD_CLOCK_SEL +: 3];
    assign high_resolution_enable =
        rate_res_r[LSB_HIGH_RESOLUTION_ENABLE +: 3];
    assign modulator_power_down   =
        shutdown_r[LSB_MODULATOR_POWER_DOWN +: 3];
    assign amplifier_power_down   =
        shutdown_r[LSB_AMPLIFIER_POWER_DOWN +: 3];
    assign fault_detect_disable   = fault_r[2:0];
    // Drive amp moves to the reference pin whenever pace takes its input
    assign pace_to_drive_input        = pace_r[BIT_PACE_TO_DRIVE_INPUT];
    assign drive_amp_to_reference_pin = pace_r[BIT_PACE_TO_DRIVE_INPUT];
    assign pace_to_wilson_pin         = pace_r[BIT_PACE_TO_WILSON_PIN];
    assign wilson_output_detach       = pace_r[BIT_PACE_TO_WILSON_PIN];
    assign pace_channel_power_down    =
        pace_r[BIT_PACE_CHANNEL_POWER_DOWN];

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read mux; unmapped addresses answer zero
    always_comb
    begin
        unique case (reg_addr)
            ADDR_CLOCK_SOURCE_CONTROL: rdata_nxt = clk_ctl_r;
            ADDR_FRONTEND_RATE_RES:    rdata_nxt = rate_res_r;
            ADDR_FRONTEND_SHUTDOWN:    rdata_nxt = shutdown_r;
            ADDR_FAULT_DETECT_CONTROL: rdata_nxt = fault_r;
            ADDR_PACE_OUTPUT_ROUTING:  rdata_nxt = pace_r;
            ADDR_LEAD_OFF_STATUS:      rdata_nxt = lead_off_r;
            ADDR_ERROR_SUMMARY_STATUS: rdata_nxt = summary_r;
            ADDR_CHAN1_RANGE_STATUS:   rdata_nxt = range_r[0];
            ADDR_CHAN2_RANGE_STATUS:   rdata_nxt = range_r[1];
            ADDR_CHAN3_RANGE_STATUS:   rdata_nxt = range_r[2];
            default:                   rdata_nxt = READ_UNMAPPED;
        endcase
    end

    // Data stands in the enabled cycle after the strobe, zero after other enabled edges; held while clk_en is low
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rdata_r <= 8'h00;
        else if (clk_en)
            rdata_r <= reg_rd ? rdata_nxt : 8'h00;
    end

    assign reg_rdata = rdata_r;

endmodule : afe_clock_control_error_status_regs

// file: rtl/afe_regs_pkg.sv
// Purpose: Constants for the clock, front-end control and error status bank
// Assumes: Byte-wide registers at byte offsets on a plain strobe port
// Notes:   Field positions are bit indices inside each 8-bit register
package afe_regs_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CLOCK_SOURCE_CONTROL  = 8'h12;
    localparam logic [7:0] ADDR_FRONTEND_RATE_RES     = 8'h13;
    localparam logic [7:0] ADDR_FRONTEND_SHUTDOWN     = 8'h14;
    localparam logic [7:0] ADDR_FAULT_DETECT_CONTROL  = 8'h15;
    localparam logic [7:0] ADDR_PACE_OUTPUT_ROUTING   = 8'h17;
    localparam logic [7:0] ADDR_LEAD_OFF_STATUS       = 8'h18;
    localparam logic [7:0] ADDR_ERROR_SUMMARY_STATUS  = 8'h19;
    localparam logic [7:0] ADDR_CHAN1_RANGE_STATUS    = 8'h1A;
    localparam logic [7:0] ADDR_CHAN2_RANGE_STATUS    = 8'h1B;
    localparam logic [7:0] ADDR_CHAN3_RANGE_STATUS    = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_DIGITAL_CLOCK_GATE     = 2;
    localparam int BIT_CLOCK_SOURCE_SELECT    = 1;
    localparam int BIT_CLOCK_PIN_DRIVE_ENABLE = 0;
    localparam int LSB_FAST_MOD_CLOCK_SEL     = 3;
    localparam int LSB_HIGH_RESOLUTION_ENABLE = 0;
    localparam int LSB_MODULATOR_POWER_DOWN   = 3;
    localparam int LSB_AMPLIFIER_POWER_DOWN   = 0;
    localparam int BIT_PACE_TO_DRIVE_INPUT    = 2;
    localparam int BIT_PACE_TO_WILSON_PIN     = 1;
    localparam int BIT_PACE_CHANNEL_POWER_DOWN = 0;

    // ------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_CLOCK_SOURCE_CONTROL = 8'h07;
    localparam logic [7:0] MASK_FRONTEND_RATE_RES    = 8'h3F;
    localparam logic [7:0] MASK_FRONTEND_SHUTDOWN    = 8'h3F;
    localparam logic [7:0] MASK_FAULT_DETECT_CONTROL = 8'h07;
    localparam logic [7:0] MASK_PACE_OUTPUT_ROUTING  = 8'h07;
    localparam logic [7:0] RST_CLOCK_SOURCE_CONTROL  = 8'h00;
    localparam logic [7:0] RST_FRONTEND_RATE_RES     = 8'h00;
    localparam logic [7:0] RST_FRONTEND_SHUTDOWN     = 8'h00;
    localparam logic [7:0] RST_FAULT_DETECT_CONTROL  = 8'h00;
    localparam logic [7:0] RST_PACE_OUTPUT_ROUTING   = 8'h01;
    localparam logic [7:0] RST_STATUS                = 8'h00;
    localparam logic [7:0] READ_UNMAPPED             = 8'h00;

    // Modulator clock rates selected by the per-channel fast bit
    localparam int MOD_CLOCK_SLOW_HZ = 102400;
    localparam int MOD_CLOCK_FAST_HZ = 204800;
endpackage : afe_regs_pkg

// file: tb/afe_regs_properties.sv
// Purpose: Port-level properties for the clock and status register bank
// Assumes: Bound onto the bank; one clock domain
// Notes:   Status capture is judged by the bench through reads
`timescale 1ns/1ns
module afe_regs_properties
    import afe_regs_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       digital_clock_gate,
    input wire logic       clock_source_select,
    input wire logic       oscillator_power_down,
    input wire logic       clock_pin_drive_enable,
    input wire logic [2:0] fast_mod_clock_sel,
    input wire logic [2:0] high_resolution_enable,
    input wire logic [2:0] modulator_power_down,
    input wire logic [2:0] amplifier_power_down,
    input wire logic [2:0] fault_detect_disable,
    input wire logic       pace_to_drive_input,
    input wire logic       drive_amp_to_reference_pin,
    input wire logic       pace_to_wilson_pin,
    input wire logic       wilson_output_detach,
    input wire logic       pace_channel_power_down
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Writes only count on enabled edges, so qualify them once here
    wire wr_ok = clk_en && reg_wr;

    unmapped_read_a: assert property (clk_en && reg_rd && reg_addr == 8'h16
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    gate_write_a: assert property (wr_ok && reg_addr == 8'h12
        |=> digital_clock_gate == $past(reg_wdata[2])
            && clock_pin_drive_enable == $past(reg_wdata[0]))
        else $error("clock control write lost");
    source_pair_a: assert property (wr_ok && reg_addr == 8'h12
        |=> clock_source_select == $past(reg_wdata[1])
            && oscillator_power_down == $past(reg_wdata[1]))
        else $error("clock source select wrong");
    pace_reset_a: assert property ($rose(resetn)
        |-> pace_channel_power_down && !pace_to_wilson_pin)
        else $error("pace reset state wrong");
    shutdown_hold_a: assert property (clk_en && !(reg_wr && reg_addr == 8'h14)
        |=> $stable(modulator_power_down) && $stable(amplifier_power_down))
        else $error("shutdown bits moved without write");
    enable_freeze_a: assert property (!clk_en
        |=> $stable(fast_mod_clock_sel) && $stable(high_resolution_enable))
        else $error("rate bits moved while disabled");
    drive_pair_a: assert property (pace_to_drive_input
        == drive_amp_to_reference_pin) else $error("drive routing split");
    wilson_write_a: assert property (wr_ok && reg_addr == 8'h17
        |=> pace_to_wilson_pin == $past(reg_wdata[1])
            && wilson_output_detach == $past(reg_wdata[1]))
        else $error("wilson routing wrong");
    rdata_idle_a: assert property (clk_en && !reg_rd
        |=> reg_rdata == 8'h00) else $error("read data outside slot");
    fault_write_a: assert property (wr_ok && reg_addr == 8'h15
        |=> fault_detect_disable == $past(reg_wdata[2:0]))
        else $error("fault disable write lost");
endmodule : afe_regs_properties

// file: tb/tb.sv
// Purpose: Self-checking bench for the clock and status register bank
// Assumes: Strobes driven by non-blocking assignment after rising edges
// Notes:   Detector inputs travel packed in one vector to keep rows short
`timescale 1ns/1ns
module tb;
    logic       clk_sys, resetn, clk_en, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] per_input_lead_off;
    logic       sync_error_flag, low_battery_flag;
    logic       drive_near_rail_flag, common_mode_range_flag;
    logic [2:0] modulator_over_range, amp_output_sign, neg_out_low_rail;
    logic [2:0] neg_out_high_rail, pos_out_low_rail, pos_out_high_rail;
    logic [2:0] diff_out_of_range, fast_mod_clock_sel;
    logic       digital_clock_gate, clock_source_select;
    logic       oscillator_power_down, clock_pin_drive_enable;
    logic [2:0] high_resolution_enable, fault_detect_disable;
    logic [2:0] modulator_power_down, amplifier_power_down;
    logic       pace_to_drive_input, drive_amp_to_reference_pin;
    logic       pace_to_wilson_pin, wilson_output_detach;
    logic       pace_channel_power_down;
    logic [30:0] stim;
    logic [23:0] pins;
    logic [7:0]  sh [8'h12:8'h17];
    logic [7:0]  st [8'h18:8'h1C];
    int          mismatches, check_count;
    logic [15:0] rows [18] = '{16'h18FF, 16'h19FF, 16'h1AFF, 16'h1BFF,
        16'h1CFF, 16'h16FF, 16'h13FF, 16'h14FF, 16'h15FF, 16'h17FF,
        16'h12FB, 16'h132A, 16'h1415, 16'h1505, 16'h1706, 16'h1700,
        16'h1202, 16'h1206};
    logic [30:0] stims [2] = '{{6'h21, 4'h4, 3'h1, 3'h2, 12'h000, 3'h4},
        {6'h00, 4'hB, 3'h0, 3'h0, 3'h1, 3'h2, 3'h4, 3'h1, 3'h0}};

    // ------------------------------------------------------------------
    // Design, clock and pin bundles
    // ------------------------------------------------------------------
    afe_clock_control_error_status_regs i_dut (.*);
    assign {per_input_lead_off, sync_error_flag, low_battery_flag,
        drive_near_rail_flag, common_mode_range_flag, modulator_over_range,
        amp_output_sign, neg_out_low_rail, neg_out_high_rail,
        pos_out_low_rail, pos_out_high_rail, diff_out_of_range} = stim;
    assign pins = {digital_clock_gate, clock_source_select,
        oscillator_power_down, clock_pin_drive_enable, fast_mod_clock_sel,
        high_resolution_enable, modulator_power_down, amplifier_power_down,
        fault_detect_disable, pace_to_drive_input, drive_amp_to_reference_pin,
        pace_to_wilson_pin, wilson_output_detach, pace_channel_power_down};
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // Writable bits per register; everything else must read back zero
    function automatic logic [7:0] msk(logic [7:0] a);
        case (a)
            8'h13, 8'h14: return 8'h3F;
            8'h12, 8'h15, 8'h17: return 8'h07;
            default: return 8'h00;
        endcase
    endfunction : msk
    task automatic clr();
        foreach (sh[i]) sh[i] = 8'h00;
        foreach (st[i]) st[i] = 8'h00;
        sh[8'h17] = 8'h01;
    endtask : clr
    // Status expectation: summary channel bit ORs range bits except sign
    task automatic set_exp(logic [30:0] s);
        logic [2:0] ce;
        for (int c = 0; c < 3; c++)
        begin
            st[8'h1A + c] = {1'b0, s[18+c], s[15+c], s[12+c], s[9+c],
                s[6+c], s[3+c], s[c]};
            ce[c] = |(st[8'h1A + c] & 8'h5F);
        end
        st[8'h18] = {2'b00, s[30:25]};
        st[8'h19] = {s[24], ce, |s[30:25], s[23:21]};
    endtask : set_exp
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        if (clk_en && a >= 8'h12 && a <= 8'h17) sh[a] = d & msk(a);
    endtask : wr
    task automatic rd(logic [7:0] a);
        logic [7:0] e;
        e = (a >= 8'h12 && a <= 8'h17) ? sh[a] : 8'h00;
        if (a >= 8'h18 && a <= 8'h1C) e = st[a];
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, reg_rdata});
    endtask : rd
    task automatic chk_out();
        chk("pins", {sh[8'h12][2], sh[8'h12][1], sh[8'h12][1:0],
            sh[8'h13][5:0], sh[8'h14][5:0], sh[8'h15][2:0], sh[8'h17][2],
            sh[8'h17][2:1], sh[8'h17][1:0]}, pins);
    endtask : chk_out
    task automatic status_pass(int i);
        @(posedge clk_sys);
        stim <= stims[i];
        repeat (3) @(posedge clk_sys);
        for (int a = 8'h18; a <= 8'h1C; a++) rd(8'(a));
    endtask : status_pass
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, stim} = '0;
        clk_en = 1'b1;
        mismatches = 0;
        check_count = 0;
        clr();
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int a = 8'h12; a <= 8'h1C; a++) rd(8'(a));
        chk_out();
        // Rows: status and unmapped writes first, while the gate is off
        foreach (rows[i])
        begin
            wr(rows[i][15:8], rows[i][7:0]);
            rd(rows[i][15:8]);
            chk_out();
        end
        for (int i = 0; i < 2; i++)
        begin
            set_exp(stims[i]);
            status_pass(i);
        end
        // Gate off: detector change must not reach the status registers
        wr(8'h12, 8'h02);
        status_pass(0);
        wr(8'h12, 8'h06);
        set_exp(stims[0]);
        status_pass(0);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(8'h13, 8'h00);
        clk_en <= 1'b1;
        rd(8'h13);
        chk_out();
        // Mid-run reset: asynchronous, checked before any edge lands
        @(posedge clk_sys);
        resetn <= 1'b0;
        clr();
        @(negedge clk_sys);
        chk_out();
        @(posedge clk_sys);
        resetn <= 1'b1;
        rd(8'h17);
        rd(8'h18);
        finish_test();
    end
    initial
    begin
        #100000;
        mismatches++;
        finish_test();
    end
endmodule : tb

bind afe_clock_control_error_status_regs afe_regs_properties i_props (.*);
